// file: tpm_matcher.sv
// Polling engine: periodic presence checks, tag list walk, action apply.
// Assumes memory reads return data one cycle after mem_rd_out and that
// all inputs come from logic on the same clock.
module tpm_matcher #(
  parameter int TICK_CYCLES = tpm_pkg::UNIT_CYCLES,
  parameter logic [7:0] POLL_CODE = tpm_pkg::POLL_CODE_DEF
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic poll_cmd_in,
  input wire logic rfid_cmd_in,
  input wire logic param_wr_in,
  input wire logic [4:0] param_idx_in,
  input wire logic [7:0] param_data_in,
  input wire logic probe_done_in,
  input wire logic tag_found_in,
  input wire tpm_pkg::tpm_tag_t tag_in,
  input wire logic [7:0] mem_data_in,
  input wire logic unlock_in,
  input wire logic lock_in,
  input wire logic user_wr_in,
  output logic mem_rd_out,
  output logic [11:0] mem_addr_out,
  output logic probe_out,
  output logic polling_out,
  output logic boot_announce_out,
  output tpm_pkg::tpm_act_t act_out,
  output logic report_out,
  output logic report_text_out,
  output tpm_pkg::tpm_tag_t report_tag_out,
  output logic unlocked_out,
  output logic user_wr_ok_out,
  output logic commit_out
);
  import tpm_pkg::*;

  tpm_state_t state_reg, state_next;
  logic [17:0][7:0] params_reg;
  logic [4:0] boot_idx_reg;
  tpm_tag_t tag_reg;
  logic [11:0] cmp_ptr_reg;
  logic [7:0] cmp_left_reg, cmp_len_reg;
  logic [3:0] cmp_idx_reg;
  logic [7:0] unit_cnt_reg, hold_tmo_reg;
  logic cmp_ok_reg, rd_pend_reg, restart_reg, dirty_reg, tick;
  tpm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .restart_in(restart_reg),
    .tick_out(tick)
  );
  // Memory read pacing: one read in flight, data valid while rd_pend_reg.
  wire idle_rd = !mem_rd_out && !rd_pend_reg;
  wire boot_issue = (state_reg == ST_BOOT) && idle_rd;
  wire boot_data = (state_reg == ST_BOOT) && rd_pend_reg;
  wire boot_skip = boot_data && (boot_idx_reg == 5'h00) && (mem_data_in != POLL_CODE);
  wire boot_go = boot_data && (boot_idx_reg == PARAM_BYTES);
  // List walk decode; a bad length ends the walk as a miss.
  wire cmp_issue = (state_reg == ST_CMP) && idle_rd && (cmp_left_reg != 8'h00);
  wire list_end = (state_reg == ST_CMP) && idle_rd && (cmp_left_reg == 8'h00);
  wire cmp_data = (state_reg == ST_CMP) && rd_pend_reg;
  wire at_len = (cmp_idx_reg == 4'h0);
  wire len_ok = (mem_data_in == LEN_SHORT) || (mem_data_in == LEN_MID) ||
                (mem_data_in == LEN_LONG);
  wire [7:0] uid_byte = tag_reg.uid[cmp_idx_reg - 4'h1];
  wire byte_eq = (uid_byte == mem_data_in);
  wire last_byte = !at_len && (cmp_idx_reg == cmp_len_reg[3:0]);
  wire cmp_stop = cmp_data && at_len && !len_ok;
  wire cmp_hit = cmp_data && last_byte && cmp_ok_reg && byte_eq;
  wire cmp_miss = cmp_stop || list_end;
  // Chosen action group and its fields.
  wire [4:0] grp = cmp_hit ? P_DEF : P_UND;
  wire [7:0] g_mode = params_reg[grp + G_MODE];
  wire [7:0] g_io = params_reg[grp + G_IO];
  wire act_on = cmp_hit || (cmp_miss && (g_mode != MODE_OFF));
  wire rep_on = act_on && ((g_mode == MODE_TEXT) || (g_mode == MODE_PACKET));
  // Unit counting for the period and the hold timeout; zero reads as one.
  wire [7:0] unit_plus = unit_cnt_reg + 8'h01;
  wire [7:0] per_units = (params_reg[P_PERIOD] == 8'h00) ? 8'h01 : params_reg[P_PERIOD];
  wire [7:0] tmo_units = (hold_tmo_reg == 8'h00) ? 8'h01 : hold_tmo_reg;
  wire period_due = (state_reg == ST_WAIT) && tick && (unit_plus >= per_units);
  wire hold_due = (state_reg == ST_HOLD) && tick && (unit_plus >= tmo_units);
  wire stop_cmd = rfid_cmd_in && !poll_cmd_in;
  // Next state; a new polling command restarts, any other command stops.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: begin
        if (boot_skip) begin
          state_next = ST_IDLE;
        end else if (boot_go) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (period_due) begin
          state_next = ST_PROBE;
        end
      end
      ST_PROBE: begin
        if (probe_done_in) begin
          state_next = tag_found_in ? ST_CMP : ST_WAIT;
        end
      end
      ST_CMP: begin
        if (cmp_hit || cmp_miss) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_due) begin
          state_next = ST_WAIT;
        end
      end
      ST_IDLE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (stop_cmd) begin
      state_next = ST_IDLE;
    end
    if (poll_cmd_in) begin
      state_next = ST_WAIT;
    end
  end

  wire enter_unit = ((state_next == ST_WAIT) || (state_next == ST_HOLD)) &&
                    (state_next != state_reg);
  wire polling_next = (state_next != ST_IDLE) && (state_next != ST_BOOT);

  // Sequencing state, boot loader and list walker.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ST_BOOT;
      params_reg <= '0;
      boot_idx_reg <= 5'h00;
      tag_reg <= '0;
      cmp_ptr_reg <= LIST_BASE;
      cmp_left_reg <= 8'h00;
      cmp_len_reg <= 8'h00;
      cmp_idx_reg <= 4'h0;
      cmp_ok_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_addr_out <= AUTO_BASE;
      unit_cnt_reg <= 8'h00;
      restart_reg <= 1'b0;
      polling_out <= 1'b0;
      probe_out <= 1'b0;
      boot_announce_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      polling_out <= polling_next;
      restart_reg <= enter_unit;
      probe_out <= period_due && !stop_cmd && !poll_cmd_in;
      boot_announce_out <= boot_skip;
      rd_pend_reg <= mem_rd_out;
      mem_rd_out <= boot_issue || cmp_issue;
      if (boot_issue) begin
        mem_addr_out <= AUTO_BASE + {7'h00, boot_idx_reg};
      end else if (cmp_issue) begin
        mem_addr_out <= cmp_ptr_reg;
      end
      if (enter_unit) begin
        unit_cnt_reg <= 8'h00;
      end else if (tick) begin
        unit_cnt_reg <= unit_plus;
      end
      if (param_wr_in && (param_idx_in < PARAM_BYTES)) begin
        params_reg[param_idx_in] <= param_data_in;
      end else if (boot_data && (boot_idx_reg != 5'h00)) begin
        params_reg[boot_idx_reg - 5'h01] <= mem_data_in;
      end
      if (boot_data) begin
        boot_idx_reg <= boot_idx_reg + 5'h01;
      end
      if ((state_reg == ST_PROBE) && probe_done_in && tag_found_in) begin
        tag_reg <= tag_in;
        cmp_ptr_reg <= LIST_BASE;
        cmp_left_reg <= params_reg[P_COUNT];
        cmp_idx_reg <= 4'h0;
      end else if (cmp_data) begin
        cmp_ptr_reg <= cmp_ptr_reg + 12'h001;
        if (at_len) begin
          cmp_len_reg <= mem_data_in;
          cmp_ok_reg <= (mem_data_in == tag_reg.len);
          cmp_idx_reg <= 4'h1;
        end else if (last_byte) begin
          cmp_left_reg <= cmp_left_reg - 8'h01;
          cmp_idx_reg <= 4'h0;
        end else begin
          cmp_ok_reg <= cmp_ok_reg && byte_eq;
          cmp_idx_reg <= cmp_idx_reg + 4'h1;
        end
      end
    end
  end

  // Outputs of the action set; pins and pulse output return on timeout.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      act_out <= '0;
      hold_tmo_reg <= 8'h00;
      report_out <= 1'b0;
      report_text_out <= 1'b0;
      report_tag_out <= '0;
    end else begin
      report_out <= rep_on && !stop_cmd && !poll_cmd_in;
      if (stop_cmd || poll_cmd_in || hold_due) begin
        act_out <= '0;
      end else if (act_on) begin
        act_out.io_en <= g_io[7:4];
        act_out.io_lvl <= g_io[3:0];
        act_out.pwm_sel <= params_reg[grp + G_PWM];
        act_out.duty <= params_reg[grp + G_DUTY];
        act_out.period_us <= {params_reg[grp + G_PER_HI], params_reg[grp + G_PER_MID],
                              params_reg[grp + G_PER_LO]};
      end
      if (cmp_hit || cmp_miss) begin
        hold_tmo_reg <= params_reg[grp + G_TMO];
      end
      if (rep_on) begin
        report_text_out <= (g_mode == MODE_TEXT);
        report_tag_out <= tag_reg;
      end
    end
  end

  // Memory lock: writes count only while unlocked, commit waits for lock.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      unlocked_out <= 1'b0;
      dirty_reg <= 1'b0;
      user_wr_ok_out <= 1'b0;
      commit_out <= 1'b0;
    end else begin
      user_wr_ok_out <= user_wr_in && unlocked_out;
      commit_out <= lock_in && (dirty_reg || (user_wr_in && unlocked_out));
      dirty_reg <= (user_wr_in && unlocked_out) || (dirty_reg && !lock_in);
      unlocked_out <= unlock_in || (unlocked_out && !lock_in);
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_probe_after_wait: assert property (probe_out |-> $past(state_reg) == ST_WAIT && $past(tick))
    else $error("probe without a due period");
  a_list_first_read: assert property ((state_reg == ST_PROBE && probe_done_in && tag_found_in &&
    params_reg[P_COUNT] != 8'h00 && !rfid_cmd_in && !poll_cmd_in) |=> ##1
    (mem_rd_out && mem_addr_out == LIST_BASE))
    else $error("list walk did not start at its base");
  a_bad_len_stop: assert property (cmp_stop && !rfid_cmd_in && !poll_cmd_in |=>
    state_reg == ST_HOLD && !mem_rd_out)
    else $error("walk went on after a bad length");
  a_count_exhaust: assert property (list_end && !rfid_cmd_in && !poll_cmd_in |=>
    state_reg == ST_HOLD)
    else $error("walk did not end at entry count");
  a_hit_actions: assert property (cmp_hit && !rfid_cmd_in && !poll_cmd_in |=>
    act_out.io_en == $past(params_reg[P_DEF + G_IO][7:4]))
    else $error("defined pins not applied");
  a_undef_off: assert property (cmp_miss && params_reg[P_UND + G_MODE] == MODE_OFF |=>
    !report_out && act_out == $past(act_out))
    else $error("action taken with undefined reporting off");
  a_report_form: assert property (cmp_hit && params_reg[P_DEF + G_MODE] == MODE_TEXT &&
    !rfid_cmd_in && !poll_cmd_in |=> report_out && report_text_out)
    else $error("text report missing");
  a_timeout_clear: assert property (hold_due && !poll_cmd_in && !rfid_cmd_in |=>
    act_out == '0 && state_reg == ST_WAIT)
    else $error("timeout did not clear actions");
  a_stop_cmd: assert property (stop_cmd |=> !polling_out && act_out == '0)
    else $error("polling survived a command");
  a_commit_lock: assert property (commit_out |-> $past(lock_in))
    else $error("commit without lock");
  a_boot_quiet: assert property (boot_go && !stop_cmd |=> !boot_announce_out && polling_out)
    else $error("autostart announced or failed");

  c_hit: cover property (cmp_hit);
  c_miss_report: cover property (cmp_miss && rep_on);
  c_autostart: cover property (boot_go);
  c_commit: cover property (commit_out);
endmodule

// file: tpm_pkg.sv
// Shared constants and carrier types for the tag polling list matcher.
// Assumes a single 40 MHz clock and a byte-wide user memory read port.
package tpm_pkg;

  // Clock rate and the 100 ms unit that period and timeout bytes count in.
  localparam int CLK_HZ = 40_000_000;
  localparam int UNIT_MS = 100;
  localparam int UNIT_CYCLES = CLK_HZ / 1000 * UNIT_MS;
  localparam int TICK_W = 23;

  // User memory layout: auto-start block at 0, tag list right after it.
  localparam logic [11:0] AUTO_BASE = 12'h000;
  localparam logic [11:0] LIST_BASE = 12'h013;
  localparam logic [4:0] PARAM_BYTES = 5'h12;

  // Offsets inside the polling parameter block.
  localparam logic [4:0] P_PERIOD = 5'h00;
  localparam logic [4:0] P_COUNT = 5'h01;
  localparam logic [4:0] P_DEF = 5'h02;
  localparam logic [4:0] P_UND = 5'h0A;

  // Offsets inside one action group, relative to its base.
  localparam logic [4:0] G_MODE = 5'h00;
  localparam logic [4:0] G_IO = 5'h01;
  localparam logic [4:0] G_PWM = 5'h02;
  localparam logic [4:0] G_DUTY = 5'h03;
  localparam logic [4:0] G_PER_HI = 5'h04;
  localparam logic [4:0] G_PER_MID = 5'h05;
  localparam logic [4:0] G_PER_LO = 5'h06;
  localparam logic [4:0] G_TMO = 5'h07;

  // Report modes.
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_PACKET = 8'h01;
  localparam logic [7:0] MODE_TEXT = 8'h03;

  // Identifier lengths accepted in the list.
  localparam logic [7:0] LEN_SHORT = 8'h04;
  localparam logic [7:0] LEN_MID = 8'h07;
  localparam logic [7:0] LEN_LONG = 8'h0A;

  // Arbitrary default for the stored polling command code.
  localparam logic [7:0] POLL_CODE_DEF = 8'h01;

  // One bit flips per step around WAIT, PROBE, CMP, HOLD and back to WAIT.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b100,
    ST_WAIT = 3'b001,
    ST_PROBE = 3'b011,
    ST_CMP = 3'b010,
    ST_HOLD = 3'b000,
    ST_BOOT = 3'b101
  } tpm_state_t;

  typedef struct packed {
    logic [3:0] io_en;
    logic [3:0] io_lvl;
    logic [7:0] pwm_sel;
    logic [7:0] duty;
    logic [23:0] period_us;
  } tpm_act_t;

  typedef struct packed {
    logic [7:0] len;
    logic [9:0][7:0] uid;
  } tpm_tag_t;

endpackage

// file: tpm_tick.sv
// Free counter that pulses once per 100 ms unit.
// Assumes restart_in comes from logic on the same clock.
module tpm_tick #(
  parameter int TICK_CYCLES = tpm_pkg::UNIT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  output logic tick_out
);
  import tpm_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] cnt_reg;
  wire at_last = (cnt_reg == TICK_LAST);

  // Restart realigns the unit, but it lands a cycle after a wait begins, so a tick in that first cycle still counts a unit.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_reg <= (restart_in || at_last) ? '0 : cnt_reg + 1'b1;
      tick_out <= at_last && !restart_in;
    end
  end
endmodule

// file: tpm_mem_model.sv
// User memory model standing behind the matcher's byte read port.
// Assumes the bench loads bytes through the write strobe while idle.
module tpm_mem_model (
  input wire logic sys_clk_in,
  input wire logic rd_in,
  input wire logic [11:0] addr_in,
  input wire logic wr_in,
  input wire logic [11:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] data_out
);
  logic [7:0] mem_reg [0:4095];
  logic [7:0] held_reg;
  logic hold_reg = 1'b0;
  logic [7:0] junk_reg = 8'h3C;

  // Data stands with the read pulse and one cycle after; otherwise it churns.
  assign data_out = rd_in ? mem_reg[addr_in] : (hold_reg ? held_reg : junk_reg);

  // Loading is untimed so the whole list fits inside the reset span.
  always @(posedge wr_in) begin
    mem_reg[wr_addr_in] <= wr_data_in;
  end

  // Read capture and a bus pattern that never repeats the last value.
  always_ff @(posedge sys_clk_in) begin
    hold_reg <= rd_in;
    junk_reg <= {junk_reg[6:0], ~junk_reg[7]};
    if (rd_in) begin
      held_reg <= mem_reg[addr_in];
    end
  end
endmodule

// file: tag_polling_list_matcher_tb.sv
// Self-checking bench for the tag polling list matcher.
// Assumes a short unit of 8 cycles in place of 100 ms.
module tag_polling_list_matcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpm_pkg::*;
  localparam int TK = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic poll_cmd, rfid_cmd, param_wr, probe_done, found, unlock, lock, user_wr, m_wr;
  logic [4:0] param_idx;
  logic [7:0] param_data, mem_data, m_data;
  logic [11:0] m_addr, mem_addr;
  tpm_tag_t tag, rep_tag;
  tpm_act_t act;
  logic mem_rd, probe, polling, announce, report, rep_text, unlocked, wr_ok, commit;
  int err_total = 0;
  int num_checks = 0;
  int cnt_ok = 0, cnt_com = 0, cnt_ann = 0, cnt_prb = 0;
  logic [7:0] prm [0:17];
  logic [7:0] lens [0:4] = '{8'h04, 8'h07, 8'h0A, 8'h05, 8'h04};
  tpm_tag_t ent [0:4];

  tpm_matcher #(.TICK_CYCLES(TK)) i_dut (.sys_clk_in(clk), .reset_in(rst),
    .poll_cmd_in(poll_cmd), .rfid_cmd_in(rfid_cmd), .param_wr_in(param_wr),
    .param_idx_in(param_idx), .param_data_in(param_data), .probe_done_in(probe_done),
    .tag_found_in(found), .tag_in(tag), .mem_data_in(mem_data), .unlock_in(unlock),
    .lock_in(lock), .user_wr_in(user_wr), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
    .probe_out(probe), .polling_out(polling), .boot_announce_out(announce),
    .act_out(act), .report_out(report), .report_text_out(rep_text),
    .report_tag_out(rep_tag), .unlocked_out(unlocked), .user_wr_ok_out(wr_ok),
    .commit_out(commit));

  tpm_mem_model i_mem (.sys_clk_in(clk), .rd_in(mem_rd), .addr_in(mem_addr),
    .wr_in(m_wr), .wr_addr_in(m_addr), .wr_data_in(m_data), .data_out(mem_data));

  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Pulse counters, so a one-cycle output is never missed by a late look.
  always @(posedge clk) begin
    if (wr_ok === 1'b1) cnt_ok++;
    if (commit === 1'b1) cnt_com++;
    if (announce === 1'b1) cnt_ann++;
    if (probe === 1'b1) cnt_prb++;
  end

  task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic load(input logic [11:0] a, input logic [7:0] v);
    m_addr = a;
    m_data = v;
    m_wr = 1'b1;
    #1 m_wr = 1'b0;
    #1;
  endtask

  task automatic setp(input int i, input logic [7:0] v);
    prm[i] = v;
    param_idx = 5'(i);
    param_data = v;
    param_wr = 1'b1;
    step();
    param_wr = 1'b0;
  endtask

  task automatic ctl(input logic [2:0] k);
    {unlock, lock, user_wr} = k;
    step();
    {unlock, lock, user_wr} = 3'b000;
    repeat (3) step();
  endtask

  task automatic to_probe(output int n);
    n = 0;
    while (probe !== 1'b1 && n < 1000) begin
      step();
      n++;
    end
    chk("probe wait", n < 1000, 1'b1);
  endtask

  // Action group as it must appear: IO byte, PWM, duty, big-endian period.
  function automatic tpm_act_t grp(input int b);
    grp = {prm[b + 1], prm[b + 2], prm[b + 3], prm[b + 4], prm[b + 5], prm[b + 6]};
  endfunction

  // Answers a pending probe with tag t and watches the hold that follows.
  task automatic present(input tpm_tag_t t, input bit hit);
    int n, hold, seen, b, tmo;
    bit on;
    tpm_act_t e;
    b = hit ? 2 : 10;
    on = hit || prm[10] != MODE_OFF;
    e = on ? grp(b) : '0;
    tmo = (prm[b + 7] == 8'h00) ? 1 : int'(prm[b + 7]);
    tag = t;
    {found, probe_done} = 2'b11;
    step();
    {found, probe_done} = 2'b00;
    n = 0;
    hold = 0;
    seen = 0;
    while (probe !== 1'b1 && n < 1000) begin
      if (report === 1'b1) begin
        seen++;
        chk("report form", rep_text, prm[b] == MODE_TEXT);
        chk("report tag", rep_tag, t);
      end
      if (act !== '0) begin
        hold++;
        chk("actions", act, e);
      end
      step();
      n++;
    end
    chk("probe back", n < 1000, 1'b1);
    chk("report count", 88'(seen), 88'(on));
    chk("hold", on ? (hold > (tmo - 1) * TK && hold <= tmo * TK + 4) : hold == 0, 1'b1);
  endtask

  // Watchdog sized well past the expected thousand or so cycles.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    logic [11:0] a;
    int n, m;
    tpm_tag_t u;
    {poll_cmd, rfid_cmd, param_wr, probe_done, found, unlock, lock, user_wr, m_wr} = '0;
    param_idx = '0;
    param_data = '0;
    tag = '0;
    m_addr = '0;
    m_data = '0;
    void'($urandom(32'h01d6_0546));
    prm = '{8'h02, 8'h05, 8'h03, 8'hA1, 8'h01, 8'h32, 8'h00, 8'h07, 8'hD0, 8'h02,
      8'h01, 8'h41, 8'h03, 8'h32, 8'h00, 8'h01, 8'hF4, 8'h01};
    // Autostart block at 0, then the list packed from 0x13 with a bad length.
    load(12'h000, POLL_CODE_DEF);
    for (int i = 0; i < 18; i++) load(12'(i + 1), prm[i]);
    a = 12'h013;
    for (int k = 0; k < 5; k++) begin
      ent[k] = '0;
      ent[k].len = lens[k];
      load(a, lens[k]);
      a++;
      for (int j = 0; j < int'(lens[k]); j++) begin
        ent[k].uid[j] = 8'($urandom);
        load(a, ent[k].uid[j]);
        a++;
      end
    end
    repeat (6) @(posedge clk);
    #2 rst = 1'b0;
    to_probe(n);
    chk("autostart", {polling, 32'(cnt_ann)}, 33'h1_0000_0000);
    present(ent[1], 1'b1);
    for (int r = 0; r < 4; r++) present(ent[$urandom_range(0, 2)], 1'b1);
    u = '0;
    u.len = LEN_SHORT;
    u.uid[3:0] = $urandom;
    present(u, 1'b0);
    present(ent[4], 1'b0);
    setp(1, 8'h01);
    present(ent[1], 1'b0);
    setp(1, 8'h05);
    {found, probe_done} = 2'b01;
    step();
    probe_done = 1'b0;
    to_probe(n);
    chk("probe gap", n >= 2 * TK - 2 && n <= 2 * TK + 6, 1'b1);
    setp(10, MODE_OFF);
    present(u, 1'b0);
    setp(10, MODE_PACKET);
    tag = ent[0];
    {found, probe_done} = 2'b11;
    step();
    {found, probe_done} = 2'b00;
    n = 0;
    while (act === '0 && n < 300) begin
      step();
      n++;
    end
    chk("act wait", n < 300, 1'b1);
    chk("select tag", rep_tag, ent[0]);
    rfid_cmd = 1'b1;
    step();
    rfid_cmd = 1'b0;
    step();
    chk("stop", {polling, act}, '0);
    m = cnt_prb;
    repeat (40) step();
    chk("no probe", 88'(cnt_prb - m), '0);
    poll_cmd = 1'b1;
    step();
    poll_cmd = 1'b0;
    to_probe(n);
    chk("restart", polling, 1'b1);
    ctl(3'b001);
    chk("locked write", 88'(cnt_ok), '0);
    ctl(3'b100);
    chk("unlocked", unlocked, 1'b1);
    ctl(3'b010);
    chk("clean lock", {unlocked, 32'(cnt_com)}, '0);
    ctl(3'b100);
    ctl(3'b001);
    chk("write ok", 88'(cnt_ok), 88'(1));
    ctl(3'b010);
    chk("commit", 88'(cnt_com), 88'(1));
    rst = 1'b1;
    load(12'h000, 8'h00);
    repeat (6) step();
    rst = 1'b0;
    m = cnt_ann;
    repeat (60) step();
    chk("announce", {polling, 32'(cnt_ann - m)}, 33'h0_0000_0001);
    close_out();
  end
endmodule
